// ---- shared/fsr_pkg.sv ----
// Constants and types shared by the floppy status and rate register block
`default_nettype none
package fsr_pkg;

  // ----------------------------------------
  // Register byte offsets on the slave bus
  // ----------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFF_STATUS = 5'h00;
  localparam logic [4:0] OFF_RATE_SEL = 5'h04;
  localparam logic [4:0] OFF_LEGACY_RATE = 5'h08;
  localparam logic [4:0] OFF_OUT_CTL = 5'h0C;
  localparam logic [4:0] OFF_TAPE_SLOT = 5'h10;
  localparam logic [4:0] OFF_DATA = 5'h14;
  localparam logic [4:0] OFF_BLK_STATE = 5'h18;

  // ----------------------------------------
  // Values after hardware reset
  // ----------------------------------------
  localparam logic [7:0] RATE_SEL_RST = 8'h02;
  localparam logic [7:0] OUT_CTL_RST = 8'h04;
  localparam logic [1:0] TAPE_SLOT_RST = 2'h0;
  localparam logic [7:0] START_TRACK_RST = 8'h00;
  localparam logic [7:0] STATUS_IDLE = 8'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int RS_SRST_BIT = 7;
  localparam int RS_LOWPWR_BIT = 6;
  localparam int RS_PRE_LSB = 2;
  localparam int OC_RESET_BIT = 2;
  localparam int BLK_SLEEP_BIT = 7;
  localparam int BLK_RESET_BIT = 6;
  localparam int BLK_READY_BIT = 5;

  // ----------------------------------------
  // Rate and write-shift encodings
  // ----------------------------------------
  localparam logic [1:0] RATE_1M = 2'h3;
  localparam logic [1:0] RATE_500K = 2'h0;
  localparam logic [1:0] RATE_300K = 2'h1;
  localparam logic [1:0] RATE_250K = 2'h2;
  localparam logic [9:0] KBPS_1M = 10'h3E8;
  localparam logic [9:0] KBPS_500K = 10'h1F4;
  localparam logic [9:0] KBPS_300K = 10'h12C;
  localparam logic [9:0] KBPS_250K = 10'h0FA;
  localparam logic [2:0] PRE_DEFAULT = 3'h0;
  localparam logic [2:0] PRE_ZERO = 3'h7;
  localparam logic [2:0] PRE_STEPS_NONE = 3'h0;
  localparam logic [2:0] PRE_STEPS_FAST = 3'h1;
  localparam logic [2:0] PRE_STEPS_SLOW = 3'h3;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int READY_TIME_NS = 2500;
  localparam int READY_CYCLES = READY_TIME_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 6;
  localparam logic [5:0] READY_LAST = 6'(READY_CYCLES - 1);
  localparam int SRST_TIME_NS = 100;
  localparam int SRST_CYCLES = (SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] SRST_LOAD = 2'(SRST_CYCLES);

  // ----------------------------------------
  // Power and readiness states
  // ----------------------------------------
  typedef enum logic [2:0] {
    FSR_RUN = 3'b001,
    FSR_SLEEP = 3'b010,
    FSR_WAKE = 3'b100
  } fsr_pwr_t;

endpackage : fsr_pkg
`default_nettype wire

// ---- hdl/fsr_flag.sv ----
// Sticky status flag where a set outweighs a clear, and clear-all outweighs a set
`timescale 1ns/100ps
`default_nettype none
module fsr_flag #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Controls
  input wire logic clr_all,
  input wire logic set,
  input wire logic clr,
  // State
  output logic q
);

  logic q_reg;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      q_reg <= RST_VAL;
    end else if (clr_all) begin
      q_reg <= 1'b0;
    end else if (set) begin
      q_reg <= 1'b1;
    end else if (clr) begin
      q_reg <= 1'b0;
    end
  end

  assign q = q_reg;

endmodule : fsr_flag
`default_nettype wire

// ---- hdl/fsr_decode.sv ----
// Registered decode of rate, write-shift and tape slot fields
`timescale 1ns/100ps
`default_nettype none
module fsr_decode (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Fields
  input wire logic [1:0] rate,
  input wire logic [2:0] shift_code,
  input wire logic [1:0] tape_slot,
  // Decoded
  output logic [9:0] rate_kbps,
  output logic [2:0] shift_steps,
  output logic [3:0] tape_drive_sel
);

  logic [9:0] kbps_next;
  logic [2:0] steps_next;

  always_comb begin
    unique case (rate)
      fsr_pkg::RATE_1M: kbps_next = fsr_pkg::KBPS_1M;
      fsr_pkg::RATE_500K: kbps_next = fsr_pkg::KBPS_500K;
      fsr_pkg::RATE_300K: kbps_next = fsr_pkg::KBPS_300K;
      fsr_pkg::RATE_250K: kbps_next = fsr_pkg::KBPS_250K;
    endcase
    if (shift_code == fsr_pkg::PRE_ZERO) begin
      steps_next = fsr_pkg::PRE_STEPS_NONE;
    end else if (shift_code == fsr_pkg::PRE_DEFAULT) begin
      steps_next = (rate == fsr_pkg::RATE_1M) ? fsr_pkg::PRE_STEPS_FAST : fsr_pkg::PRE_STEPS_SLOW;
    end else begin
      steps_next = shift_code;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rate_kbps <= fsr_pkg::KBPS_250K;
      shift_steps <= fsr_pkg::PRE_STEPS_SLOW;
      tape_drive_sel <= 4'h0;
    end else begin
      rate_kbps <= kbps_next;
      shift_steps <= steps_next;
      // tape slot decode, drive 0 never
      tape_drive_sel <= (tape_slot == 2'h0) ? 4'h0 : 4'(4'h1 << tape_slot);
    end
  end

endmodule : fsr_decode
`default_nettype wire

// ---- hdl/fsr_regs.sv ----
// Status and rate-select register block of the disk controller
// What this block does
// - Tape slot 00 assigns no drive, 01..11 assign drives 1..3.
// - Status register may be read at any time, even just after reset.
// - Status reads 00h while starting up, then 80h when commands are accepted.
// - Ready value 80h appears no later than 2.5 us after reset.
// - Status read right after a data transfer is already valid.
// - Host request flag drops after each byte, rises when next is possible.
// - In non-DMA execution the host request flag mirrors the interrupt.
// - Direction flag: 0 host writes, 1 host reads.
// - Non-DMA execution flag set during byte-transfer execution phase.
// - Command flag set on first byte, cleared at last result byte or at last byte of a command with no result.
// - Per-drive seek flags set by seek or recalibrate, cleared by sense.
// - Active rate comes from the last write to rate-select or legacy rate.
// - Hardware reset loads 02h into rate-select; soft reset leaves it.
// - Rate-select bit 7 resets the controller and clears itself.
// - Bit 6 enters low power; soft reset or data/status access leaves it.
// - Bits 4..2: 111 none, 001..110 in 41.7 ns steps, 000 default.
// - Default write shift: 41.7 ns at 1 Mbps, 125 ns otherwise.
// - Write shift starts at track 0, changeable by configure.
// - Rate field 11 1 Mbps, 00 500k, 01 300k, 10 250k.
// - Output-control reset bit low holds reset and reinitialises settings.
//
// Decided for this implementation: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module fsr_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register bus
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Controller core state
  input wire logic [7:0] core_rdata,
  input wire logic core_ready,
  input wire logic core_int,
  input wire logic core_dir,
  input wire logic core_nondma,
  input wire logic core_byte_done,
  // Qualifiers of the current data byte
  input wire logic core_cmd_last,
  input wire logic core_no_result,
  input wire logic core_res_first,
  input wire logic core_res_last,
  input wire logic core_seek_cmd,
  input wire logic core_sense_cmd,
  input wire logic [1:0] core_drive,
  // Configure command
  input wire logic core_cfg_we,
  input wire logic [7:0] core_cfg_track,
  // Data byte strobes
  output logic data_wr_stb,
  output logic data_rd_stb,
  output logic [7:0] data_wdata,
  // Controller control
  output logic core_reset,
  output logic osc_enable,
  output logic [1:0] data_rate,
  output logic [9:0] rate_kbps,
  output logic [2:0] precomp_steps,
  output logic [7:0] precomp_start_track,
  output logic [3:0] tape_drive_sel
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam int WAKE_MAX = 50;

  logic ack_reg;
  logic rd_go;
  logic wr_go;
  logic be_ok;
  logic d_rd;
  logic d_wr;
  logic rs_wr;
  logic srst_wr;
  logic lp_set;
  logic lp_exit;
  logic ctl_reset;
  logic srst_active;
  logic ready;
  logic host_request_flag;
  logic pend_q;
  logic cmd_q;
  logic [3:0] busy_q;
  logic [7:0] status_w;
  logic [7:0] rd_mux;
  logic [1:0] srst_cnt_reg;
  logic [5:0] cnt_reg;
  logic [7:0] rate_sel_reg;
  logic [1:0] rate_reg;
  logic [7:0] out_ctl_reg;
  logic [1:0] tape_reg;
  logic [7:0] track_reg;
  logic [7:0] blk_w;
  fsr_pkg::fsr_pwr_t pwr_reg;
  fsr_pkg::fsr_pwr_t pwr_next;

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  // Every access waits one cycle so read data come from a flop
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign rd_go = avs_read & ack_reg;
  assign wr_go = avs_write & ack_reg;
  assign be_ok = avs_byteenable[0];

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end
  end

  assign d_rd = rd_go & (avs_address == fsr_pkg::OFF_DATA);
  assign d_wr = wr_go & be_ok & (avs_address == fsr_pkg::OFF_DATA);
  assign rs_wr = wr_go & be_ok & (avs_address == fsr_pkg::OFF_RATE_SEL);
  assign srst_wr = rs_wr & avs_writedata[fsr_pkg::RS_SRST_BIT];
  assign lp_set = rs_wr & avs_writedata[fsr_pkg::RS_LOWPWR_BIT] & ~avs_writedata[fsr_pkg::RS_SRST_BIT];
  assign lp_exit = (rd_go | wr_go) & ((avs_address == fsr_pkg::OFF_STATUS) | (avs_address == fsr_pkg::OFF_DATA));

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  assign blk_w = {pwr_reg == fsr_pkg::FSR_SLEEP, ctl_reset, ready, 3'h0, rate_reg};

  always_comb begin
    unique case (avs_address)
      fsr_pkg::OFF_STATUS: rd_mux = status_w;
      fsr_pkg::OFF_OUT_CTL: rd_mux = out_ctl_reg;
      fsr_pkg::OFF_TAPE_SLOT: rd_mux = {6'h00, tape_reg};
      fsr_pkg::OFF_DATA: rd_mux = core_rdata;
      fsr_pkg::OFF_BLK_STATE: rd_mux = blk_w;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~ack_reg) begin
      avs_readdata <= {24'h00_0000, rd_mux};
    end
  end

  // ----------------------------------------
  // Written registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    // hardware reset value, soft reset untouched
    if (!nrst) begin
      rate_sel_reg <= fsr_pkg::RATE_SEL_RST;
    end else if (rs_wr) begin
      // Reset and low power bits are actions, not stored
      rate_sel_reg <= {2'h0, avs_writedata[5:0]};
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rate_reg <= fsr_pkg::RATE_SEL_RST[1:0];
    end else if (rs_wr) begin
      rate_reg <= avs_writedata[1:0];
    end else if (wr_go & be_ok & (avs_address == fsr_pkg::OFF_LEGACY_RATE)) begin
      rate_reg <= avs_writedata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      out_ctl_reg <= fsr_pkg::OUT_CTL_RST;
      tape_reg <= fsr_pkg::TAPE_SLOT_RST;
    end else if (wr_go & be_ok & (avs_address == fsr_pkg::OFF_OUT_CTL)) begin
      out_ctl_reg <= avs_writedata[7:0];
    end else if (wr_go & be_ok & (avs_address == fsr_pkg::OFF_TAPE_SLOT)) begin
      tape_reg <= avs_writedata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      track_reg <= fsr_pkg::START_TRACK_RST;
    end else if (ctl_reset) begin
      // track 0 again after controller reset
      track_reg <= fsr_pkg::START_TRACK_RST;
    end else if (core_cfg_we) begin
      track_reg <= core_cfg_track;
    end
  end

  // ----------------------------------------
  // Controller reset
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      srst_cnt_reg <= 2'h0;
    end else if (srst_wr) begin
      srst_cnt_reg <= fsr_pkg::SRST_LOAD;
    end else if (srst_cnt_reg != 2'h0) begin
      srst_cnt_reg <= srst_cnt_reg - 2'h1;
    end
  end

  assign srst_active = srst_cnt_reg != 2'h0;
  assign ctl_reset = srst_active | ~out_ctl_reg[fsr_pkg::OC_RESET_BIT];
  // Core reinitialises configure and mode settings while this is high
  assign core_reset = ctl_reset;

  // ----------------------------------------
  // Power and readiness
  // ----------------------------------------
  always_comb begin
    pwr_next = pwr_reg;
    if (ctl_reset) begin
      pwr_next = fsr_pkg::FSR_WAKE;
    end else begin
      unique case (pwr_reg)
        fsr_pkg::FSR_RUN: begin
          if (lp_set) pwr_next = fsr_pkg::FSR_SLEEP;
        end
        fsr_pkg::FSR_SLEEP: begin
          if (lp_exit) pwr_next = fsr_pkg::FSR_WAKE;
        end
        fsr_pkg::FSR_WAKE: begin
          if (lp_set) pwr_next = fsr_pkg::FSR_SLEEP;
          else if (cnt_reg == fsr_pkg::READY_LAST) pwr_next = fsr_pkg::FSR_RUN;
        end
        default: pwr_next = fsr_pkg::FSR_WAKE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pwr_reg <= fsr_pkg::FSR_WAKE;
    end else begin
      pwr_reg <= pwr_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_reg <= 6'h00;
    end else if (ctl_reset || pwr_reg != fsr_pkg::FSR_WAKE) begin
      cnt_reg <= 6'h00;
    end else if (cnt_reg != fsr_pkg::READY_LAST) begin
      cnt_reg <= cnt_reg + 6'h01;
    end
  end

  assign ready = (pwr_reg == fsr_pkg::FSR_RUN) & ~ctl_reset;
  // Oscillator stops only in manual low power
  assign osc_enable = pwr_reg != fsr_pkg::FSR_SLEEP;

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  // byte pending until core takes it
  fsr_flag u_pend (
    .clk(clk),
    .nrst(nrst),
    .clr_all(ctl_reset),
    .set(d_rd | d_wr),
    .clr(core_byte_done),
    .q(pend_q)
  );

  fsr_flag u_cmd (
    .clk(clk),
    .nrst(nrst),
    .clr_all(ctl_reset),
    .set(d_wr & ~cmd_q & ~(core_cmd_last & core_no_result)),
    .clr((d_wr & core_cmd_last & core_no_result) | (d_rd & core_res_last)),
    .q(cmd_q)
  );

  for (genvar i = 0; i < 4; i++) begin : g_busy
    fsr_flag u_busy (
      .clk(clk),
      .nrst(nrst),
      .clr_all(ctl_reset),
      .set(d_wr & core_cmd_last & core_seek_cmd & (core_drive == 2'(i))),
      .clr(d_rd & core_res_first & core_sense_cmd & (core_drive == 2'(i))),
      .q(busy_q[i])
    );
  end

  assign host_request_flag = core_nondma ? core_int : (core_ready & ~pend_q);
  // zero until ready, direction and execution
  assign status_w = ready ? {host_request_flag, core_dir, core_nondma, cmd_q, busy_q} : fsr_pkg::STATUS_IDLE;

  // ----------------------------------------
  // Data strobes and decoded outputs
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      data_wr_stb <= 1'b0;
      data_rd_stb <= 1'b0;
      data_wdata <= 8'h00;
    end else begin
      data_wr_stb <= d_wr;
      data_rd_stb <= d_rd;
      if (d_wr) data_wdata <= avs_writedata[7:0];
    end
  end

  assign data_rate = rate_reg;
  assign precomp_start_track = track_reg;

  fsr_decode u_decode (
    .clk(clk),
    .nrst(nrst),
    .rate(rate_reg),
    .shift_code(rate_sel_reg[4:2]),
    .tape_slot(tape_reg),
    .rate_kbps(rate_kbps),
    .shift_steps(precomp_steps),
    .tape_drive_sel(tape_drive_sel)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  ready_time_a: assert property (
    @(posedge clk) disable iff (!nrst || ctl_reset || lp_set)
    (pwr_reg == fsr_pkg::FSR_WAKE && cnt_reg == 6'h00) |-> ##[1:WAKE_MAX] (pwr_reg == fsr_pkg::FSR_RUN))
    else $error("Status not ready in time");

  idle_zero_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (rd_go && avs_address == fsr_pkg::OFF_STATUS && $past(pwr_reg) != fsr_pkg::FSR_RUN) |->
    (avs_readdata[7:0] == 8'h00))
    else $error("Status not zero while starting");

  host_req_drop_a: assert property (
    @(posedge clk) disable iff (!nrst)
    ((d_rd | d_wr) && !ctl_reset) |=> (core_nondma || !status_w[7]))
    else $error("Host request stayed set after byte");

  int_mirror_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (ready && core_nondma) |-> (status_w[7] == core_int))
    else $error("Host request does not mirror interrupt");

  cmd_set_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (d_wr && !cmd_q && !core_cmd_last && !ctl_reset) |=> cmd_q ##0 (status_w[4] || !ready))
    else $error("Command flag not set on first byte");

  seek_busy_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (d_wr && core_cmd_last && core_seek_cmd && !ctl_reset) |=> busy_q[$past(core_drive)])
    else $error("Seek flag not set");

  hw_rate_a: assert property (
    @(posedge clk)
    !nrst |=> (rate_sel_reg == 8'h02 && rate_reg == 2'h2))
    else $error("Rate select wrong after reset");

  srst_pulse_a: assert property (
    @(posedge clk) disable iff (!nrst)
    srst_wr |=> srst_active[*2] ##1 (!srst_active || $past(srst_wr)))
    else $error("Soft reset pulse length wrong");

  lp_exit_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (pwr_reg == fsr_pkg::FSR_SLEEP && lp_exit) |=> (pwr_reg == fsr_pkg::FSR_WAKE && osc_enable))
    else $error("Low power not left on access");

  rate_last_a: assert property (
    @(posedge clk) disable iff (!nrst)
    (wr_go && be_ok && avs_address == fsr_pkg::OFF_LEGACY_RATE) |=> (data_rate == $past(avs_writedata[1:0])))
    else $error("Legacy write did not set rate");

endmodule : fsr_regs
`default_nettype wire

// ---- verification/fsr_core_model.sv ----
// Controller core stand-in that answers the data byte strobes
`timescale 1ns/100ps
`default_nettype none
module fsr_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Byte strobes and pacing
  input wire logic data_wr_stb,
  input wire logic data_rd_stb,
  input wire logic slow,
  // Core handshake
  output logic core_ready,
  output logic core_byte_done,
  output logic [7:0] core_rdata
);
  logic [3:0] wait_reg;
  // ----------------------------------------
  // Byte handshake
  // ----------------------------------------
  // Slow pacing keeps a byte pending long enough for the host to see it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      core_ready <= 1'b1;
      core_byte_done <= 1'b0;
      core_rdata <= 8'h5a;
      wait_reg <= 4'h0;
    end else begin
      core_byte_done <= 1'b0;
      if (data_wr_stb || data_rd_stb) begin
        core_ready <= 1'b0;
        wait_reg <= slow ? 4'h8 : 4'h1;
      end else if (wait_reg == 4'h1) begin
        core_ready <= 1'b1;
        core_byte_done <= 1'b1;
        // New byte each time so a stale read shows up
        core_rdata <= ~core_rdata;
        wait_reg <= 4'h0;
      end else if (wait_reg != 4'h0) begin
        wait_reg <= wait_reg - 4'h1;
      end
    end
  end
endmodule : fsr_core_model
`default_nettype wire

// ---- verification/tb_fsr_regs.sv ----
// Self-checking bench for the status and rate-select register block
`timescale 1ns/100ps
`default_nettype none
module tb_fsr_regs;
  logic clk, nrst, avs_read, avs_write, avs_waitrequest, core_int, core_dir, core_nondma, slow, cfg_we;
  logic core_ready, core_byte_done, data_wr_stb, data_rd_stb, core_reset, osc_enable;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [7:0] core_rdata, data_wdata, cfg_track, precomp_start_track, s;
  logic [5:0] qual;
  logic [1:0] drive, data_rate;
  logic [9:0] rate_kbps;
  logic [9:0] kbps_tab [4];
  logic [2:0] precomp_steps, exp_steps;
  logic [3:0] tape_drive_sel, be;
  int err_total, n_compared, cycles, r, c, hits;

  fsr_regs u_fsr_regs (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(be), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .core_rdata(core_rdata),
    .core_ready(core_ready), .core_int(core_int), .core_dir(core_dir), .core_nondma(core_nondma),
    .core_byte_done(core_byte_done), .core_cmd_last(qual[5]), .core_no_result(qual[4]),
    .core_res_first(qual[3]), .core_res_last(qual[2]), .core_seek_cmd(qual[1]),
    .core_sense_cmd(qual[0]), .core_drive(drive), .core_cfg_we(cfg_we), .core_cfg_track(cfg_track),
    .data_wr_stb(data_wr_stb), .data_rd_stb(data_rd_stb), .data_wdata(data_wdata),
    .core_reset(core_reset), .osc_enable(osc_enable), .data_rate(data_rate), .rate_kbps(rate_kbps),
    .precomp_steps(precomp_steps), .precomp_start_track(precomp_start_track),
    .tape_drive_sel(tape_drive_sel));

  fsr_core_model u_fsr_core_model (.clk(clk), .nrst(nrst), .data_wr_stb(data_wr_stb),
    .data_rd_stb(data_rd_stb), .slow(slow), .core_ready(core_ready),
    .core_byte_done(core_byte_done), .core_rdata(core_rdata));

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h00_0000, d};
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic poll;
    for (int i = 0; i < 40; i++) begin
      bus(1'b0, fsr_pkg::OFF_STATUS, 8'h00);
      if (q[7] === 1'b1) break;
    end
    s = q[7:0];
  endtask : poll

  task automatic results;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Ceiling well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      err_total++;
      results();
    end
  end

  initial begin
    {nrst, avs_read, avs_write, core_int, core_dir, core_nondma, cfg_we} = '0;
    {avs_address, avs_writedata, cfg_track, qual, drive} = '0;
    slow = 1'b1;
    be = 4'h1;
    kbps_tab = '{fsr_pkg::KBPS_500K, fsr_pkg::KBPS_300K, fsr_pkg::KBPS_250K, fsr_pkg::KBPS_1M};
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    // ----------------------------------------
    // Start-up status and reset values
    // ----------------------------------------
    bus(1'b0, fsr_pkg::OFF_STATUS, 8'h00);
    check(q, 32'h0000_0000);
    check({precomp_start_track, data_rate, precomp_steps, tape_drive_sel}, 32'h0000_0130);
    check(rate_kbps, fsr_pkg::KBPS_250K);
    repeat (48) @(posedge clk);
    bus(1'b0, fsr_pkg::OFF_STATUS, 8'h00);
    check(q, 32'h0000_0080);
    bus(1'b0, fsr_pkg::OFF_RATE_SEL, 8'h00);
    check(q, 32'h0000_0000);
    bus(1'b0, 5'h1c, 8'h00);
    check(q, 32'h0000_0000);
    // ----------------------------------------
    // Seek then sense on drive two
    // ----------------------------------------
    // host polls after each byte, bit five kept clear
    bus(1'b1, fsr_pkg::OFF_DATA, 8'h0f);
    @(posedge clk);
    check(data_wdata, 8'h0f);
    bus(1'b0, fsr_pkg::OFF_STATUS, 8'h00);
    check(q, 32'h0000_0010);
    poll();
    check(s, 8'h90);
    qual <= 6'b110010;
    drive <= 2'h2;
    bus(1'b1, fsr_pkg::OFF_DATA, 8'h02);
    poll();
    check(s, 8'h84);
    qual <= 6'b000000;
    bus(1'b1, fsr_pkg::OFF_DATA, 8'h08);
    poll();
    check(s, 8'h94);
    qual <= 6'b100000;
    bus(1'b1, fsr_pkg::OFF_DATA, 8'h02);
    core_dir <= 1'b1;
    poll();
    check(s, 8'hd4);
    qual <= 6'b001001;
    bus(1'b0, fsr_pkg::OFF_DATA, 8'h00);
    check(q, 32'h0000_005a);
    poll();
    check(s, 8'hd0);
    // Fast pacing for the last result byte
    slow <= 1'b0;
    qual <= 6'b000100;
    bus(1'b0, fsr_pkg::OFF_DATA, 8'h00);
    check(q, 32'h0000_00a5);
    poll();
    check(s, 8'hc0);
    qual <= 6'b000000;
    core_nondma <= 1'b1;
    bus(1'b0, fsr_pkg::OFF_STATUS, 8'h00);
    check(q, 32'h0000_0060);
    core_int <= 1'b1;
    core_dir <= 1'b0;
    bus(1'b0, fsr_pkg::OFF_STATUS, 8'h00);
    check(q, 32'h0000_00a0);
    core_nondma <= 1'b0;
    core_int <= 1'b0;
    // ----------------------------------------
    // Rate, write shift and tape slot decode
    // ----------------------------------------
    for (r = 0; r < 4; r++) begin
      for (c = 0; c < 8; c++) begin
        bus(1'b1, fsr_pkg::OFF_RATE_SEL, {3'b000, c[2:0], r[1:0]});
        repeat (3) @(posedge clk);
        exp_steps = (c == 7) ? 3'h0 : (c != 0) ? c[2:0] : (r == 3) ? 3'h1 : 3'h3;
        check(data_rate, r[1:0]);
        check(rate_kbps, kbps_tab[r]);
        check(precomp_steps, exp_steps);
      end
    end
    bus(1'b1, fsr_pkg::OFF_LEGACY_RATE, 8'h01);
    repeat (3) @(posedge clk);
    check(data_rate, 2'h1);
    for (r = 0; r < 4; r++) begin
      bus(1'b1, fsr_pkg::OFF_TAPE_SLOT, {6'h00, r[1:0]});
      repeat (3) @(posedge clk);
      check(tape_drive_sel, (r == 0) ? 4'h0 : 4'h1 << r);
    end
    // ----------------------------------------
    // Soft reset, output-control reset and low power
    // ----------------------------------------
    cfg_track <= 8'h27;
    cfg_we <= 1'b1;
    @(posedge clk);
    cfg_we <= 1'b0;
    repeat (2) @(posedge clk);
    check(precomp_start_track, 8'h27);
    bus(1'b1, fsr_pkg::OFF_RATE_SEL, 8'h81);
    hits = 0;
    repeat (6) begin
      @(posedge clk);
      hits += int'(core_reset === 1'b1);
    end
    check(hits, 2);
    check({precomp_start_track, data_rate}, 10'h001);
    repeat (55) @(posedge clk);
    bus(1'b0, fsr_pkg::OFF_STATUS, 8'h00);
    check(q, 32'h0000_0080);
    bus(1'b1, fsr_pkg::OFF_OUT_CTL, 8'h00);
    repeat (8) @(posedge clk);
    check(core_reset, 1'b1);
    bus(1'b1, fsr_pkg::OFF_OUT_CTL, 8'h04);
    repeat (2) @(posedge clk);
    check(core_reset, 1'b0);
    // Write without byte lane zero must be ignored
    be <= 4'h0;
    bus(1'b1, fsr_pkg::OFF_OUT_CTL, 8'h00);
    be <= 4'h1;
    repeat (2) @(posedge clk);
    check(core_reset, 1'b0);
    bus(1'b1, fsr_pkg::OFF_RATE_SEL, 8'h41);
    repeat (2) @(posedge clk);
    check(osc_enable, 1'b0);
    bus(1'b0, fsr_pkg::OFF_BLK_STATE, 8'h00);
    check(q, 32'h0000_0081);
    bus(1'b0, fsr_pkg::OFF_STATUS, 8'h00);
    repeat (2) @(posedge clk);
    check(osc_enable, 1'b1);
    repeat (55) @(posedge clk);
    bus(1'b0, fsr_pkg::OFF_STATUS, 8'h00);
    check(q, 32'h0000_0080);
    results();
  end
endmodule : tb_fsr_regs
`default_nettype wire
